// ### common/isp_pkg.sv
// Notes on behaviour
// - send programming enable before program or erase
// - data bit valid at rising serial clock edge
// - each clock phase exceeds device clock limits
// - power-up: reset and clock low, reset pulse
// - wait 20 ms before programming enable
// - always send four bytes; bad echo retries
// - low byte loaded before high byte
// - extended address byte kept until reloaded
// - never access port before write ends
// - set extended address before flash reads
// - releasing reset ends programming mode
// - poll until busy bit reads zero
package isp_pkg;
    localparam logic [7:0] OP_PROG_ENABLE = 8'hAC;
    localparam logic [7:0] PE_SECOND = 8'h53;
    localparam logic [7:0] ERASE_SECOND = 8'h80;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_LOAD_EXT_ADDR = 8'h4D;
    localparam logic [7:0] OP_LOAD_PAGE_HIGH = 8'h48;
    localparam logic [7:0] OP_LOAD_PAGE_LOW = 8'h40;
    localparam logic [7:0] OP_LOAD_EE_PAGE = 8'hC1;
    localparam logic [7:0] OP_READ_HIGH = 8'h28;
    localparam logic [7:0] OP_READ_LOW = 8'h20;
    localparam logic [7:0] OP_READ_EE = 8'hA0;
    localparam logic [7:0] OP_READ_FUSE_LOW = 8'h50;
    localparam logic [7:0] OP_READ_FUSE_HIGH = 8'h58;
    localparam logic [7:0] OP_READ_SIGNATURE = 8'h30;
    localparam logic [7:0] OP_READ_CALIB = 8'h38;
    localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
    localparam logic [7:0] OP_WRITE_EE = 8'hC0;
    localparam logic [7:0] OP_WRITE_EE_PAGE = 8'hC2;
    localparam logic [31:0] PE_WORD = 32'hAC53_0000;
    localparam logic [31:0] POLL_WORD = 32'hF000_0000;
    localparam logic [5:0] BITS_PER_CMD = 6'h20;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned SCK_HALF_NS = 200;
    localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RST_PULSE_NS = 1000;
    localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned POWERUP_WAIT_MS = 20;
    localparam int unsigned POWERUP_WAIT_CYC =
        (POWERUP_WAIT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FIFO_DEPTH = 8;
endpackage

// ### rtl/isp_fifo.sv
`timescale 1ns/10ps
module isp_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            count <= next_count;
            // registered so the upstream port sees a flop
            in_ready <= (next_count < FULL_COUNT);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // isp_fifo

// ### rtl/isp_ctrl.sv
`timescale 1ns/10ps
module isp_ctrl #(
    parameter int unsigned POWERUP_WAIT = isp_pkg::POWERUP_WAIT_CYC,
    parameter int unsigned RST_PULSE = isp_pkg::RST_PULSE_CYC,
    parameter int unsigned SCK_HALF = isp_pkg::SCK_HALF_CYC,
    parameter int unsigned FIFO_DEPTH = isp_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [31:0] cmd_data,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic prog_enabled,
    output logic echo_bad,
    output logic pin_reset_n,
    output logic pin_sck,
    output logic pin_mosi,
    input wire logic pin_miso
);
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_PULSE,
        ST_SETTLE,
        ST_ENABLE,
        ST_IDLE,
        ST_CMD,
        ST_POLL,
        ST_OFF
    } isp_state_t;

    isp_state_t state;
    logic [31:0] wait_cnt;
    logic [31:0] cur_cmd;
    logic sh_start;
    logic [31:0] sh_word;
    logic sh_busy;
    logic sh_done;
    logic [31:0] sh_tx;
    logic [31:0] sh_rx;
    logic [4:0] bit_idx;
    logic [15:0] div_cnt;
    logic miso_meta;
    logic miso_s;
    logic fifo_valid;
    logic [31:0] fifo_data;
    logic fifo_pop;

    // commands that start a self-timed write in the target
    function automatic logic needs_poll(input logic [31:0] c);
        logic [7:0] b1;
        logic [7:0] b2;
        b1 = c[31:24];
        b2 = c[23:16];
        needs_poll = (b1 == isp_pkg::OP_WRITE_PAGE) ||
                     (b1 == isp_pkg::OP_WRITE_EE) ||
                     (b1 == isp_pkg::OP_WRITE_EE_PAGE) ||
                     ((b1 == isp_pkg::OP_PROG_ENABLE) &&
                      (b2 != isp_pkg::PE_SECOND));
    endfunction

    // command queue; strict order keeps low-before-high page loads
    isp_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // queue drains only once programming is enabled
    assign fifo_pop = (state == ST_IDLE) && run && fifo_valid;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            miso_meta <= 1'b0;
            miso_s <= 1'b0;
        end else begin
            miso_meta <= pin_miso;
            miso_s <= miso_meta;
        end
    end

    // serial shifter: one sck phase is SCK_HALF clocks
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sh_busy <= 1'b0;
            sh_done <= 1'b0;
            sh_tx <= 32'h0000_0000;
            sh_rx <= 32'h0000_0000;
            bit_idx <= 5'h00;
            div_cnt <= 16'h0000;
            pin_sck <= 1'b0;
            pin_mosi <= 1'b0;
        end else begin
            sh_done <= 1'b0;
            if (!sh_busy) begin
                if (sh_start) begin
                    sh_busy <= 1'b1;
                    sh_tx <= sh_word;
                    pin_mosi <= sh_word[31];
                    bit_idx <= 5'h00;
                    div_cnt <= 16'h0000;
                end
            end else if (div_cnt == 16'(SCK_HALF - 1)) begin
                div_cnt <= 16'h0000;
                if (!pin_sck) begin
                    pin_sck <= 1'b1;
                    // target drove miso at the falling edge a phase ago
                    sh_rx <= {sh_rx[30:0], miso_s};
                end else begin
                    pin_sck <= 1'b0;
                    // next bit set up a full phase before rising edge
                    sh_tx <= {sh_tx[30:0], 1'b0};
                    pin_mosi <= sh_tx[30];
                    bit_idx <= bit_idx + 5'h01;
                    if (bit_idx == 5'(isp_pkg::BITS_PER_CMD - 6'h01)) begin
                        sh_busy <= 1'b0;
                        sh_done <= 1'b1;
                    end
                end
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end

    // session sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_HOLD;
            wait_cnt <= 32'h0000_0000;
            pin_reset_n <= 1'b0;
            prog_enabled <= 1'b0;
            sh_start <= 1'b0;
            sh_word <= 32'h0000_0000;
            cur_cmd <= 32'h0000_0000;
        end else begin
            sh_start <= 1'b0;
            case (state)
                ST_HOLD: begin
                    pin_reset_n <= 1'b0;
                    if (!run) begin
                        state <= ST_OFF;
                        pin_reset_n <= 1'b1;
                    end else if (wait_cnt == RST_PULSE - 1) begin
                        wait_cnt <= 32'h0000_0000;
                        pin_reset_n <= 1'b1;
                        state <= ST_PULSE;
                    end else begin
                        wait_cnt <= wait_cnt + 32'h0000_0001;
                    end
                end
                ST_PULSE: begin
                    if (wait_cnt == RST_PULSE - 1) begin
                        wait_cnt <= 32'h0000_0000;
                        pin_reset_n <= 1'b0;
                        state <= ST_SETTLE;
                    end else begin
                        wait_cnt <= wait_cnt + 32'h0000_0001;
                    end
                end
                ST_SETTLE: begin
                    if (wait_cnt == POWERUP_WAIT - 1) begin
                        wait_cnt <= 32'h0000_0000;
                        sh_start <= 1'b1;
                        sh_word <= isp_pkg::PE_WORD;
                        state <= ST_ENABLE;
                    end else begin
                        wait_cnt <= wait_cnt + 32'h0000_0001;
                    end
                end
                ST_ENABLE: begin
                    if (sh_done) begin
                        // echo sits in the third byte received
                        if (sh_rx[15:8] == isp_pkg::PE_SECOND) begin
                            prog_enabled <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            pin_reset_n <= 1'b1;
                            state <= ST_PULSE;
                        end
                    end
                end
                ST_IDLE: begin
                    if (!run) begin
                        pin_reset_n <= 1'b1;
                        prog_enabled <= 1'b0;
                        state <= ST_OFF;
                    end else if (fifo_valid) begin
                        sh_start <= 1'b1;
                        sh_word <= fifo_data;
                        cur_cmd <= fifo_data;
                        state <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (sh_done) begin
                        if (needs_poll(cur_cmd)) begin
                            sh_start <= 1'b1;
                            sh_word <= isp_pkg::POLL_WORD;
                            state <= ST_POLL;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_POLL: begin
                    if (sh_done) begin
                        if (sh_rx[0]) begin
                            sh_start <= 1'b1;
                            sh_word <= isp_pkg::POLL_WORD;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_OFF: begin
                    pin_reset_n <= 1'b1;
                    if (run) begin
                        pin_reset_n <= 1'b0;
                        wait_cnt <= 32'h0000_0000;
                        state <= ST_HOLD;
                    end
                end
                default: begin
                    state <= ST_HOLD;
                    pin_reset_n <= 1'b0;
                end
            endcase
        end
    end

    // answers: byte four of each user command, and echo failures
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resp_valid <= 1'b0;
            resp_data <= 8'h00;
            echo_bad <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            echo_bad <= 1'b0;
            if (state == ST_CMD && sh_done) begin
                resp_valid <= 1'b1;
                resp_data <= sh_rx[7:0];
            end
            if (state == ST_ENABLE && sh_done) begin
                echo_bad <= (sh_rx[15:8] != isp_pkg::PE_SECOND);
            end
        end
    end
endmodule // isp_ctrl

// ### test/isp_ctrl_sva.sv
`timescale 1ns/10ps
module isp_ctrl_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic resp_valid,
    input wire logic prog_enabled,
    input wire logic echo_bad,
    input wire logic pin_reset_n,
    input wire logic pin_sck,
    input wire logic pin_mosi
);
    localparam int RST_WIN = 8;
    logic sck_q;
    logic [4:0] rises;
    logic [4:0] rises_now;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // count includes a rise seen this very edge
    assign rises_now = rises + 5'(pin_sck && !sck_q);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_q <= 1'h0;
            rises <= 5'h00;
        end else begin
            sck_q <= pin_sck;
            rises <= rises_now;
        end
    end
    AST_SCK_LOW: assert property (
        $rose(pin_sck) |-> !$past(pin_sck, 3)) else $error("sck low short");
    AST_SCK_HIGH: assert property (
        $fell(pin_sck) |-> $past(pin_sck, 4)) else $error("sck high short");
    AST_MOSI_HOLD: assert property (
        pin_sck |-> $stable(pin_mosi)) else $error("mosi moved, sck high");
    AST_SCK_IN_RESET: assert property (
        pin_sck |-> !pin_reset_n) else $error("sck with target free");
    AST_RESP_ENABLED: assert property (
        resp_valid |-> prog_enabled) else $error("command before enable");
    AST_FRAME_LEN: assert property (
        resp_valid || $rose(prog_enabled) |-> rises_now == 5'h00)
        else $error("frame not 32 edges");
    AST_ECHO_RETRY: assert property (
        echo_bad |-> !prog_enabled ##[0:RST_WIN] pin_reset_n)
        else $error("no reset pulse after bad echo");
    AST_RELEASE: assert property (
        $fell(prog_enabled) |-> pin_reset_n && !$past(run))
        else $error("session end without release");
    COV_ECHO: cover property (echo_bad);
    COV_RESP: cover property (resp_valid);
    COV_END: cover property ($fell(prog_enabled));
endmodule // isp_ctrl_sva

bind isp_ctrl isp_ctrl_sva u_sva (
    .clk, .reset, .run, .resp_valid, .prog_enabled, .echo_bad,
    .pin_reset_n, .pin_sck, .pin_mosi
);

// ### test/isp_dev_model.sv
`timescale 1ns/10ps
module isp_dev_model #(
    parameter logic [47:0] CFG = 48'h000000000000
) (
    input wire logic rst_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic garble,
    output logic miso
);
    logic [31:0] rx;
    logic [7:0] tx = 8'h00;
    logic [7:0] fl [256];
    logic [7:0] pg [256];
    logic [7:0] ee [256];
    logic [7:0] ep [4] = '{default: 8'hFF};
    logic [7:0] cfg [6];
    int n;
    int busy;
    bit en;
    // unselected line shows the inverse, never a held bit
    assign miso = rst_n ? ~tx[7] : tx[7];
    initial begin
        foreach (cfg[i]) begin
            cfg[i] = CFG[47-8*i -: 8];
        end
    end
    function automatic logic [7:0] rd();
        case (rx[23:16])
            8'h20: return fl[{rx[6:0], 1'h0}];
            8'h28: return fl[{rx[6:0], 1'h1}];
            8'hA0: return ee[rx[7:0]];
            8'h50: return cfg[rx[11] ? 2 : 0];
            8'h58: return cfg[rx[11] ? 1 : 3];
            8'h30: return cfg[4];
            8'h38: return cfg[5];
            8'hF0: return {7'h00, busy > 0};
            default: return 8'h00;
        endcase
    endfunction
    task automatic exec();
        if (rx[31:24] == 8'hF0 && busy > 0) begin
            busy = busy - 1;
        end
        if (rx[31:16] == 16'hAC53) begin
            en = 1'h1;
        end else if (en) begin
            case (rx[31:24])
                8'h40: pg[{rx[14:8], 1'h0}] = rx[7:0];
                8'h48: pg[{rx[14:8], 1'h1}] = rx[7:0];
                8'h4C: fl = pg;
                8'hC0: ee[rx[15:8]] = rx[7:0];
                8'hC1: ep[rx[9:8]] = rx[7:0];
                8'hC2: begin
                    foreach (ep[i]) begin
                        ee[{rx[15:10], 2'(i)}] = ep[i];
                    end
                end
                8'hAC: begin
                    if (rx[23:16] == 8'hA0) begin
                        cfg[0] = rx[7:0];
                    end
                    if (rx[23:16] == 8'h80) begin
                        foreach (fl[i]) begin
                            fl[i] = 8'hFF;
                            ee[i] = 8'hFF;
                        end
                    end
                end
                default: ;
            endcase
            // two busy polls make the answer slow on purpose
            if (rx[31:24] inside {8'h4C, 8'hC0, 8'hC2, 8'hAC}) begin
                busy = 2;
            end
        end
    endtask
    always @(posedge sck or posedge rst_n) begin
        if (rst_n) begin
            n = 0;
            en = 1'h0;
        end else begin
            rx = {rx[30:0], mosi};
            n = n + 1;
            if (n == 32) begin
                n = 0;
                exec();
            end
        end
    end
    always @(negedge sck) begin
        if (n % 8 != 0) begin
            tx = tx << 1;
        end else if (n == 24) begin
            tx = rd();
        end else begin
            tx = rx[7:0] ^ {8{garble && n == 16}};
        end
    end
endmodule // isp_dev_model

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
    // signature and calibration bytes are arbitrary
    localparam logic [47:0] CFG = 48'h62D9FFFF5AA7;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic run = 1'h0;
    logic cmd_valid = 1'h0;
    logic [31:0] cmd_data = 32'h00000000;
    logic garble = 1'h1;
    logic cmd_ready, resp_valid, prog_enabled, echo_bad;
    logic pin_reset_n, pin_sck, pin_mosi, pin_miso;
    logic [7:0] resp_data;
    logic [3:0] flags;
    int n_fail = 0;
    int total_checks = 0;
    assign flags = {!prog_enabled, prog_enabled, echo_bad, resp_valid};
    always #25 clk = ~clk;
    isp_ctrl #(.POWERUP_WAIT(50), .RST_PULSE(3)) u_dut (
        .clk, .reset, .run, .cmd_valid, .cmd_ready, .cmd_data,
        .resp_valid, .resp_data, .prog_enabled, .echo_bad,
        .pin_reset_n, .pin_sck, .pin_mosi, .pin_miso
    );
    isp_dev_model #(.CFG(CFG)) u_dev (
        .rst_n(pin_reset_n), .sck(pin_sck), .mosi(pin_mosi),
        .garble(garble), .miso(pin_miso)
    );
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] exp, input logic [7:0] got,
                         input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_sig(input int sel, input string what);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (flags[sel] === 1'h1) begin
                break;
            end
        end
        if (i == 4000) begin
            check(8'h01, 8'h00, what);
            close_out();
        end
    endtask
    // returns at the negedge after the word was taken, valid still up
    task automatic issue(input logic [31:0] w);
        int i;
        cmd_valid = 1'h1;
        cmd_data = w;
        for (i = 0; i < 4000 && cmd_ready !== 1'h1; i++) begin
            @(negedge clk);
        end
        if (i == 4000) begin
            check(8'h01, 8'h00, "cmd_ready");
            close_out();
        end
        @(negedge clk);
    endtask
    task automatic xfer(input logic [39:0] t);
        issue(t[39:8]);
        cmd_valid = 1'h0;
        wait_sig(0, "resp_valid");
        check(t[7:0], resp_data, "resp_data");
    endtask
    // queue fills while no session runs, then a bad echo forces a retry
    task automatic fill_then_start();
        logic [39:0] ta [8] = '{
            40'h4D00000000,
            40'h400005A500,
            40'h4800055A00,
            40'h4C00000000,
            40'h20000500A5,
            40'h280005005A,
            40'hC000107700,
            40'hA000100077};
        foreach (ta[i]) begin
            issue(ta[i][39:8]);
        end
        check(8'h00, {7'h00, cmd_ready}, "cmd_ready");
        cmd_valid = 1'h0;
        run = 1'h1;
        wait_sig(1, "echo_bad");
        garble = 1'h0;
        wait_sig(2, "prog_enabled");
        foreach (ta[i]) begin
            wait_sig(0, "resp_valid");
            check(ta[i][7:0], resp_data, "resp_data");
        end
    endtask
    task automatic config_table();
        logic [39:0] tc [14] = '{
            {32'h50000000, CFG[47:40]},
            {32'h58080000, CFG[39:32]},
            {32'h50080000, CFG[31:24]},
            {32'h58000000, CFG[23:16]},
            {32'h30000000, CFG[15:8]},
            {32'h38000000, CFG[7:0]},
            40'hACA0003C00,
            40'h500000003C,
            40'hAC80000000,
            40'h20000500FF,
            40'hA0001000FF,
            40'hC100014400,
            40'hC200200000,
            40'hA000210044};
        foreach (tc[i]) begin
            xfer(tc[i]);
        end
    endtask
    task automatic release_session();
        run = 1'h0;
        wait_sig(3, "prog_enabled low");
        check(8'h01, {7'h00, pin_reset_n}, "pin_reset_n");
        run = 1'h1;
        wait_sig(2, "prog_enabled");
        xfer(40'hA0001000FF);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'h0;
        fill_then_start();
        config_table();
        release_session();
        close_out();
    end
endmodule // testbench
